/* File: dv/pca_cmp_assertions.sv */
// Purpose: Port-level checker of the compare/PWM block
// Assumes: Checker sees only top ports; mode shadows follow bus writes
// Notes:   Shadows cover channels 0 and 1 and the run bit
`timescale 1ns/1ps
module pca_cmp_chk (
	input wire logic                    ref_clk,
	input wire logic                    rst_n,
	input wire logic [7:0]              reg_addr,
	input wire logic [7:0]              reg_wdata,
	input wire logic                    reg_wr,
	input wire logic                    reg_rd,
	input wire logic [7:0]              reg_rdata,
	input wire logic [pca_pkg::NCH-1:0] channel_io_pin,
	input wire logic                    irq_req
);
	logic [7:0] m_q [2];
	logic       run_q;

	// Shadow of channel modes, with compare enable side effects of byte writes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			m_q[0] <= 8'h00;
			m_q[1] <= 8'h00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (reg_wr && reg_addr == 8'h10 + 8'(i * 4)) m_q[i] <= reg_wdata;
				if (reg_wr && reg_addr == 8'h11 + 8'(i * 4)) m_q[i][6] <= 1'b0;
				if (reg_wr && reg_addr == 8'h12 + 8'(i * 4)) m_q[i][6] <= 1'b1;
			end
		end
	end

	// Shadow of the counter run bit
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 1'b0;
		end else if (reg_wr && reg_addr == 8'h00) begin
			run_q <= reg_wdata[6];
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not idle");
	unmapped_rd_a: assert property (reg_rd && reg_addr == 8'hff |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	div_echo_a: assert property (reg_wr && reg_addr == 8'h05 ##1 reg_rd && reg_addr == 8'h05
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("divider read back wrong");
	low_clr_a: assert property (reg_wr && reg_addr == 8'h15 ##1 reg_rd && reg_addr == 8'h14
		|=> !reg_rdata[6]) else $error("low write left compare enable");
	high_set_a: assert property (reg_wr && reg_addr == 8'h16 ##1 reg_rd && reg_addr == 8'h14
		|=> reg_rdata[6]) else $error("high write left compare disabled");
	irq_hold_a: assert property (irq_req && !reg_wr |=> irq_req)
		else $error("request dropped without software");
	pwm_off_a: assert property ((run_q && m_q[0][1] && !m_q[0][6] && !m_q[0][2]) [*3]
		|-> !channel_io_pin[0]) else $error("disabled pwm pin high");
	hso_hold_a: assert property ((m_q[1][2] && !m_q[1][6] && !m_q[1][1]) [*2]
		|-> $stable(channel_io_pin[1])) else $error("disabled toggle pin moved");

	irq_seen_c: cover property ($rose(irq_req));
	pin0_rise_c: cover property ($rose(channel_io_pin[0]));
	pin1_fall_c: cover property ($fell(channel_io_pin[1]));
endmodule : pca_cmp_chk

bind pca_cmp_top pca_cmp_chk u_pca_cmp_chk (
	.ref_clk        (ref_clk),
	.rst_n          (rst_n),
	.reg_addr       (reg_addr),
	.reg_wdata      (reg_wdata),
	.reg_wr         (reg_wr),
	.reg_rd         (reg_rd),
	.reg_rdata      (reg_rdata),
	.channel_io_pin (channel_io_pin),
	.irq_req        (irq_req)
);

/* File: dv/pca_pin_mon.sv */
// Purpose: Far side of the channel pins: a sampling load
// Assumes: Pins are outputs of the block and are never driven back
// Notes:   Counts high cycles and level changes per pin since the last clear
`timescale 1ns/1ps
module pca_pin_mon (
	input  wire logic                          ref_clk,
	input  wire logic                          clr,
	input  wire logic [pca_pkg::NCH-1:0]       pin,
	output logic      [pca_pkg::NCH-1:0][15:0] hi_cnt,
	output logic      [pca_pkg::NCH-1:0][15:0] edge_cnt
);
	logic [pca_pkg::NCH-1:0] last_q;

	// Sample each system clock; no level is forced back, so hold time never binds
	always_ff @(posedge ref_clk) begin
		last_q <= pin;
		for (int i = 0; i < pca_pkg::NCH; i++) begin
			if (clr) begin
				hi_cnt[i] <= 16'h0000;
				edge_cnt[i] <= 16'h0000;
			end else begin
				hi_cnt[i] <= hi_cnt[i] + 16'(pin[i]);
				edge_cnt[i] <= edge_cnt[i] + 16'(pin[i] ^ last_q[i]);
			end
		end
	end
endmodule : pca_pin_mon

/* File: dv/tb_top.sv */
// Purpose: Self-checking bench of the compare/PWM block
// Assumes: Divider left at 0, so the counter steps every clock
// Notes:   Pin duty and edges are measured by the pin monitor
`timescale 1ns/1ps
module tb_top;
	logic                          ref_clk = 1'b0;
	logic                          rst_n = 1'b0;
	logic [7:0]                    reg_addr = 8'h00;
	logic [7:0]                    reg_wdata = 8'h00;
	logic                          reg_wr = 1'b0;
	logic                          reg_rd = 1'b0;
	logic                          clr = 1'b0;
	logic [7:0]                    reg_rdata;
	logic [7:0]                    d;
	logic [pca_pkg::NCH-1:0]       pin;
	logic                          irq_req;
	logic [pca_pkg::NCH-1:0][15:0] hi_cnt;
	logic [pca_pkg::NCH-1:0][15:0] edge_cnt;
	int                            miscompares = 0;
	int                            samples_checked = 0;
	int                            cyc_n = 0;

	pca_cmp_top u_pca_cmp_top (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.channel_io_pin(pin), .irq_req(irq_req));
	pca_pin_mon u_pca_pin_mon (.ref_clk(ref_clk), .clr(clr), .pin(pin), .hi_cnt(hi_cnt),
		.edge_cnt(edge_cnt));

	// Clock and hang guard
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			miscompares++;
			test_done();
		end
	end

	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk

	// Bus write: strobe stays up until the next task lowers it
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	task automatic cyc(input int n);
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		repeat (n - 1) @(posedge ref_clk);
		#1;
	endtask : cyc

	// Clear the pin tallies, then let n cycles be counted
	task automatic meas(input int n);
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : meas

	task automatic t_regs;
		rd(8'h00);
		chk("ctrl", 16'(d), 16'h0000);
		rd(8'h01);
		chk("amode", 16'(d), 16'h0000);
		wr(8'h05, 8'h5a);
		rd(8'h05);
		chk("div", 16'(d), 16'h005a);
		wr(8'h05, 8'h00);
		wr(8'hff, 8'h33);
		rd(8'hff);
		chk("unmapped", 16'(d), 16'h0000);
		$display("t_regs done");
	endtask : t_regs

	task automatic t_timer;
		wr(8'h03, 8'h00);
		wr(8'h04, 8'h00);
		wr(8'h19, 8'h20);
		wr(8'h1a, 8'h00);
		wr(8'h18, 8'h49);
		wr(8'h00, 8'h40);
		cyc(24);
		chk("irq early", 16'(irq_req), 16'h0000);
		cyc(24);
		chk("irq", 16'(irq_req), 16'h0001);
		rd(8'h00);
		chk("flag2", 16'(d[2]), 16'h0001);
		chk("pin2 idle", 16'(pin[2]), 16'h0000);
		cyc(200);
		chk("irq held", 16'(irq_req), 16'h0001);
		wr(8'h00, 8'h00);
		wr(8'h18, 8'h00);
		cyc(2);
		chk("irq clr", 16'(irq_req), 16'h0000);
		$display("t_timer done");
	endtask : t_timer

	task automatic run0(input logic [7:0] lo, input logic [7:0] hi);
		wr(8'h00, 8'h00);
		wr(8'h03, lo);
		wr(8'h04, hi);
	endtask : run0

	task automatic t_hso;
		wr(8'h14, 8'h4c);
		wr(8'h15, 8'h10);
		rd(8'h14);
		chk("mode low", 16'(d), 16'h000c);
		wr(8'h16, 8'h00);
		rd(8'h14);
		chk("mode high", 16'(d), 16'h004c);
		run0(8'h00, 8'h00);
		wr(8'h00, 8'h40);
		cyc(32);
		chk("pin1 t1", 16'(pin[1]), 16'h0001);
		rd(8'h00);
		chk("flag1", 16'(d[1]), 16'h0001);
		run0(8'h00, 8'h00);
		wr(8'h15, 8'h10);
		wr(8'h00, 8'h40);
		cyc(32);
		chk("pin1 hold", 16'(pin[1]), 16'h0001);
		run0(8'h00, 8'h00);
		wr(8'h16, 8'h00);
		wr(8'h00, 8'h40);
		cyc(32);
		chk("pin1 t2", 16'(pin[1]), 16'h0000);
		$display("t_hso done");
	endtask : t_hso

	task automatic t_wrap;
		run0(8'hf0, 8'hff);
		wr(8'h01, 8'h01);
		wr(8'h00, 8'h40);
		cyc(32);
		rd(8'h00);
		chk("wrap flag", 16'(d[7]), 16'h0001);
		chk("wrap irq", 16'(irq_req), 16'h0001);
		wr(8'h01, 8'h00);
		cyc(2);
		chk("wrap mask", 16'(irq_req), 16'h0000);
		$display("t_wrap done");
	endtask : t_wrap

	task automatic t_pwm8;
		wr(8'h02, 8'h00);
		wr(8'h11, 8'h80);
		wr(8'h12, 8'h80);
		wr(8'h10, 8'h4a);
		cyc(300);
		meas(256);
		chk("hi8", hi_cnt[0], 16'h0080);
		chk("edge8", edge_cnt[0], 16'h0002);
		rd(8'h00);
		chk("flag0", 16'(d[0]), 16'h0001);
		rd(8'h02);
		chk("ovf8", 16'(d[5]), 16'h0001);
		wr(8'h12, 8'h40);
		cyc(300);
		meas(256);
		chk("reload8", hi_cnt[0], 16'h00c0);
		wr(8'h11, 8'h40);
		cyc(2);
		meas(256);
		chk("off8", hi_cnt[0], 16'h0000);
		$display("t_pwm8 done");
	endtask : t_pwm8

	task automatic t_pwm9;
		wr(8'h00, 8'h00);
		wr(8'h02, 8'h41);
		wr(8'h11, 8'h00);
		wr(8'h12, 8'h01);
		rd(8'h12);
		chk("reload hi", 16'(d), 16'h0001);
		wr(8'h02, 8'h01);
		wr(8'h10, 8'h42);
		wr(8'h00, 8'h40);
		cyc(600);
		meas(512);
		chk("hi9", hi_cnt[0], 16'h0100);
		chk("edge9", edge_cnt[0], 16'h0002);
		rd(8'h02);
		chk("ovf9", 16'(d[5]), 16'h0001);
		$display("t_pwm9 done");
	endtask : t_pwm9

	task automatic t_pwm16;
		wr(8'h02, 8'h00);
		wr(8'h15, 8'hf0);
		wr(8'h16, 8'hff);
		wr(8'h14, 8'hca);
		run0(8'he0, 8'hff);
		wr(8'h00, 8'h40);
		cyc(24);
		chk("pin16 hi", 16'(pin[1]), 16'h0001);
		rd(8'h00);
		chk("flag16", 16'(d[1]), 16'h0001);
		// Duty update only after the match was seen, high byte alone
		wr(8'h16, 8'hff);
		cyc(32);
		chk("pin16 lo", 16'(pin[1]), 16'h0000);
		rd(8'h00);
		chk("wrap16", 16'(d[7]), 16'h0001);
		$display("t_pwm16 done");
	endtask : t_pwm16

	task automatic t_freq;
		wr(8'h11, 8'h10);
		wr(8'h12, 8'h04);
		wr(8'h10, 8'h46);
		cyc(300);
		meas(64);
		chk("freq4", edge_cnt[0], 16'h0010);
		wr(8'h12, 8'h00);
		cyc(600);
		meas(512);
		chk("freq256", edge_cnt[0], 16'h0002);
		$display("t_freq done");
	endtask : t_freq

	// 11-bit then 10-bit PWM from one reload value; overflow irq follows its enable
	task automatic t_pwm11;
		wr(8'h02, 8'hc3);
		wr(8'h11, 8'h00);
		wr(8'h12, 8'h02);
		wr(8'h02, 8'h83);
		wr(8'h10, 8'h42);
		cyc(2100);
		meas(2048);
		chk("hi11", hi_cnt[0], 16'h0600);
		chk("edge11", edge_cnt[0], 16'h0002);
		chk("ovf irq", 16'(irq_req), 16'h0001);
		wr(8'h02, 8'h02);
		cyc(1100);
		meas(1024);
		chk("hi10", hi_cnt[0], 16'h0200);
		chk("edge10", edge_cnt[0], 16'h0002);
		chk("ovf mask", 16'(irq_req), 16'h0000);
		$display("t_pwm11 done");
	endtask : t_pwm11

	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	// Main sequence
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_regs();
		t_timer();
		t_hso();
		t_wrap();
		t_pwm8();
		t_pwm9();
		t_pwm16();
		t_freq();
		t_pwm11();
		test_done();
	end
endmodule : tb_top

/* File: src/pca_cmp_top.sv */
// Purpose: Compare, frequency and PWM channels of the counter array
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes:   Capture, clock source choice and watchdog are not part of this block
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module pca_cmp_top (
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	input  wire logic [7:0]              reg_addr,
	input  wire logic [7:0]              reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [7:0]              reg_rdata,
	output logic      [pca_pkg::NCH-1:0] channel_io_pin,
	output logic                         irq_req
);
	localparam int N = pca_pkg::NCH;

	pca_cnt_if cb ();

	// Array level registers
	logic        counter_wrap_flag_q;
	logic        run_q;
	logic        wrap_irq_en_q;
	logic        ovf_irq_en_q;
	logic        reload_view_select_q;
	logic        intermediate_overflow_flag_q;
	logic [1:0]  cycle_length_select_q;
	logic [7:0]  div_q;
	logic [15:0] cnt;
	logic [7:0]  rdata_q;

	// Channel registers
	logic [7:0]  mode_q [N];
	logic [15:0] cmp_q  [N];
	logic [10:0] rld_q  [N];
	logic [N-1:0] pin_q;
	logic [N-1:0] channel_event_flag_q;

	// Decoded strobes
	logic         wr_ctrl;
	logic         wr_amode;
	logic         wr_spcfg;
	logic         wr_cntl;
	logic         wr_cnth;
	logic         wr_div;
	logic [N-1:0] wr_mode;
	logic [N-1:0] wr_low;
	logic [N-1:0] wr_high;

	// Per channel mode and match terms
	logic [N-1:0] ecom;
	logic [N-1:0] mat;
	logic [N-1:0] m_sw;
	logic [N-1:0] m_hso;
	logic [N-1:0] m_frq;
	logic [N-1:0] m_pws;
	logic [N-1:0] m_p16;
	logic [N-1:0] full_m;
	logic [N-1:0] lo_m;
	logic [N-1:0] n_m;
	logic [N-1:0] flag_set;
	logic [10:0]  msk;

	// Counter and timebase
	pca_timebase u_tb (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.run     (run_q),
		.div     (div_q),
		.cls     (cycle_length_select_q),
		.wr_lo   (wr_cntl),
		.wr_hi   (wr_cnth),
		.wdata   (reg_wdata),
		.cnt_q   (cnt),
		.cb      (cb.src)
	);

	// Address decode of write strobes
	always_comb begin
		wr_ctrl  = reg_wr && (reg_addr == pca_pkg::A_CTRL);
		wr_amode = reg_wr && (reg_addr == pca_pkg::A_AMODE);
		wr_spcfg = reg_wr && (reg_addr == pca_pkg::A_SPCFG);
		wr_cntl  = reg_wr && (reg_addr == pca_pkg::A_CNTL);
		wr_cnth  = reg_wr && (reg_addr == pca_pkg::A_CNTH);
		wr_div   = reg_wr && (reg_addr == pca_pkg::A_DIV);
		for (int n = 0; n < N; n++) begin
			wr_mode[n] = reg_wr && (reg_addr == pca_pkg::ch_addr(n, pca_pkg::O_MODE));
			wr_low[n]  = reg_wr && (reg_addr == pca_pkg::ch_addr(n, pca_pkg::O_LOW));
			wr_high[n] = reg_wr && (reg_addr == pca_pkg::ch_addr(n, pca_pkg::O_HIGH));
		end
	end

	// Mode decode, and comparators that are all gated by the counter step
	always_comb begin
		msk = pca_pkg::low_mask(cycle_length_select_q);
		for (int n = 0; n < N; n++) begin
			ecom[n]   = mode_q[n][pca_pkg::M_ECOM];
			mat[n]    = mode_q[n][pca_pkg::M_MAT];
			// Software timer: compare and match set, no toggle, no pulse
			m_sw[n]   = ecom[n] && mat[n] && !mode_q[n][pca_pkg::M_TOG]
			            && !mode_q[n][pca_pkg::M_PWM];
			// High-speed output: toggle and match, no pulse
			m_hso[n]  = mat[n] && mode_q[n][pca_pkg::M_TOG]
			            && !mode_q[n][pca_pkg::M_PWM];
			// Frequency output: toggle with pulse
			m_frq[n]  = mode_q[n][pca_pkg::M_TOG] && mode_q[n][pca_pkg::M_PWM];
			// Short PWM: pulse without toggle or wide select
			m_pws[n]  = mode_q[n][pca_pkg::M_PWM] && !mode_q[n][pca_pkg::M_TOG]
			            && !mode_q[n][pca_pkg::M_WIDE];
			// Wide PWM: pulse with wide select
			m_p16[n]  = mode_q[n][pca_pkg::M_PWM] && !mode_q[n][pca_pkg::M_TOG]
			            && mode_q[n][pca_pkg::M_WIDE];
			full_m[n] = cb.tick && (cb.nxt == cmp_q[n]);
			lo_m[n]   = cb.tick && (cb.nxt[7:0] == cmp_q[n][7:0]);
			n_m[n]    = cb.tick && ((cb.nxt[10:0] & msk) == (cmp_q[n][10:0] & msk));
		end
	end

	// Flag set events per mode; matches only count while compare is on
	always_comb begin
		for (int n = 0; n < N; n++) begin
			flag_set[n] = 1'b0;
			if (ecom[n] && mat[n]) begin
				if (m_sw[n] || m_hso[n]) begin
					flag_set[n] = full_m[n];
				end else if (m_frq[n]) begin
					flag_set[n] = full_m[n];
				end else if (m_pws[n]) begin
					flag_set[n] = n_m[n];
				end else if (m_p16[n]) begin
					flag_set[n] = full_m[n];
				end
			end
		end
	end

	// Channel mode registers; compare byte writes steer compare enable
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int n = 0; n < N; n++) begin
				mode_q[n] <= pca_pkg::RST_BYTE;
			end
		end else begin
			for (int n = 0; n < N; n++) begin
				if (wr_mode[n]) begin
					mode_q[n] <= reg_wdata;
				end else if (wr_low[n]) begin
					mode_q[n][pca_pkg::M_ECOM] <= 1'b0;
				end else if (wr_high[n]) begin
					mode_q[n][pca_pkg::M_ECOM] <= 1'b1;
				end
			end
		end
	end

	// Compare and reload registers, with hardware reloads and frequency offset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int n = 0; n < N; n++) begin
				cmp_q[n] <= pca_pkg::RST_WORD;
				rld_q[n] <= pca_pkg::RST_WORD[10:0];
			end
		end else begin
			for (int n = 0; n < N; n++) begin
				if (wr_low[n] && reload_view_select_q) begin
					rld_q[n][7:0] <= reg_wdata;
				end else if (wr_high[n] && reload_view_select_q) begin
					rld_q[n][10:8] <= reg_wdata[2:0];
				end
				if (wr_low[n] && !reload_view_select_q) begin
					cmp_q[n][7:0] <= reg_wdata;
				end else if (wr_high[n] && !reload_view_select_q) begin
					cmp_q[n][15:8] <= reg_wdata;
				end else if (m_frq[n] && ecom[n] && lo_m[n]) begin
					// Eight-bit add; a zero offset wraps to the same byte
					cmp_q[n][7:0] <= cmp_q[n][7:0] + cmp_q[n][15:8];
				end else if (m_pws[n] && cb.wrapn) begin
					if (cycle_length_select_q == 2'b00) begin
						cmp_q[n][7:0] <= cmp_q[n][15:8];
					end else begin
						cmp_q[n][10:0] <= rld_q[n];
					end
				end
			end
		end
	end

	// Channel output pins
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_q <= '0;
		end else begin
			for (int n = 0; n < N; n++) begin
				if (m_hso[n]) begin
					// Without compare enable the pin keeps its level
					if (ecom[n] && full_m[n]) begin
						pin_q[n] <= !pin_q[n];
					end
				end else if (m_frq[n]) begin
					if (ecom[n] && lo_m[n]) begin
						pin_q[n] <= !pin_q[n];
					end
				end else if (m_pws[n]) begin
					if (!ecom[n]) begin
						pin_q[n] <= 1'b0;
					end else if (n_m[n]) begin
						pin_q[n] <= 1'b1;
					end else if (cb.wrapn) begin
						pin_q[n] <= 1'b0;
					end
				end else if (m_p16[n]) begin
					if (!ecom[n]) begin
						pin_q[n] <= 1'b0;
					end else if (full_m[n]) begin
						pin_q[n] <= 1'b1;
					end else if (cb.wrap16) begin
						pin_q[n] <= 1'b0;
					end
				end
			end
		end
	end

	// Channel event flags: writing zero clears, a set in the same cycle wins
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			channel_event_flag_q <= '0;
		end else begin
			for (int n = 0; n < N; n++) begin
				if (flag_set[n]) begin
					channel_event_flag_q[n] <= 1'b1;
				end else if (wr_ctrl && !reg_wdata[n]) begin
					channel_event_flag_q[n] <= 1'b0;
				end
			end
		end
	end

	// Counter wrap flag and run control
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			counter_wrap_flag_q <= 1'b0;
			run_q               <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				run_q <= reg_wdata[pca_pkg::C_RUN];
			end
			if (cb.wrap16) begin
				counter_wrap_flag_q <= 1'b1;
			end else if (wr_ctrl && !reg_wdata[pca_pkg::C_CF]) begin
				counter_wrap_flag_q <= 1'b0;
			end
		end
	end

	// Short pulse configuration and intermediate overflow flag
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ovf_irq_en_q                 <= 1'b0;
			reload_view_select_q         <= 1'b0;
			cycle_length_select_q        <= 2'b00;
			intermediate_overflow_flag_q <= 1'b0;
		end else begin
			if (wr_spcfg) begin
				ovf_irq_en_q          <= reg_wdata[pca_pkg::S_ECOV];
				reload_view_select_q  <= reg_wdata[pca_pkg::S_VIEW];
				cycle_length_select_q <= reg_wdata[1:0];
			end
			if (cb.wrapn) begin
				intermediate_overflow_flag_q <= 1'b1;
			end else if (wr_spcfg && !reg_wdata[pca_pkg::S_INTERMEDIATE_OVERFLOW_FLAG]) begin
				intermediate_overflow_flag_q <= 1'b0;
			end
		end
	end

	// Array mode and tick divider
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrap_irq_en_q <= 1'b0;
			div_q         <= pca_pkg::RST_BYTE;
		end else begin
			if (wr_amode) begin
				wrap_irq_en_q <= reg_wdata[pca_pkg::AM_ECF];
			end
			if (wr_div) begin
				div_q <= reg_wdata;
			end
		end
	end

	// Read data: stands for the one cycle after the strobe, else zero
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= pca_pkg::RST_BYTE;
		end else if (!reg_rd) begin
			rdata_q <= pca_pkg::RST_BYTE;
		end else begin
			rdata_q <= pca_pkg::RST_BYTE;
			unique case (reg_addr)
				pca_pkg::A_CTRL: begin
					rdata_q[pca_pkg::C_CF]  <= counter_wrap_flag_q;
					rdata_q[pca_pkg::C_RUN] <= run_q;
					rdata_q[N-1:0]          <= channel_event_flag_q;
				end
				pca_pkg::A_AMODE: rdata_q[pca_pkg::AM_ECF] <= wrap_irq_en_q;
				pca_pkg::A_SPCFG: begin
					rdata_q[pca_pkg::S_ECOV] <= ovf_irq_en_q;
					rdata_q[pca_pkg::S_VIEW] <= reload_view_select_q;
					rdata_q[pca_pkg::S_INTERMEDIATE_OVERFLOW_FLAG] <= intermediate_overflow_flag_q;
					rdata_q[1:0]             <= cycle_length_select_q;
				end
				pca_pkg::A_CNTL: rdata_q <= cnt[7:0];
				pca_pkg::A_CNTH: rdata_q <= cnt[15:8];
				pca_pkg::A_DIV:  rdata_q <= div_q;
				default: begin
					for (int n = 0; n < N; n++) begin
						if (reg_addr == pca_pkg::ch_addr(n, pca_pkg::O_MODE)) begin
							rdata_q <= mode_q[n];
						end else if (reg_addr == pca_pkg::ch_addr(n, pca_pkg::O_LOW)) begin
							rdata_q <= reload_view_select_q ? rld_q[n][7:0]
							                                : cmp_q[n][7:0];
						end else if (reg_addr == pca_pkg::ch_addr(n, pca_pkg::O_HIGH)) begin
							rdata_q <= reload_view_select_q ? {5'h00, rld_q[n][10:8]}
							                                : cmp_q[n][15:8];
						end
					end
				end
			endcase
		end
	end

	// Interrupt request from enabled flags
	always_comb begin
		irq_req = (counter_wrap_flag_q && wrap_irq_en_q)
		          || (intermediate_overflow_flag_q && ovf_irq_en_q);
		for (int n = 0; n < N; n++) begin
			irq_req = irq_req || (channel_event_flag_q[n]
			          && mode_q[n][pca_pkg::M_IRQ]);
		end
	end

	assign reg_rdata      = rdata_q;
	assign channel_io_pin = pin_q;
endmodule : pca_cmp_top

/* File: src/pca_cnt_if.sv */
// Purpose: Counter state handed from the timebase to the channel logic
// Assumes: Single clock domain
// Notes:   Pulses are one system clock wide and coincide with a counter step
`timescale 1ns/1ps
interface pca_cnt_if;
	logic        tick;
	logic [15:0] nxt;
	logic        wrap16;
	logic        wrapn;
	modport src  (output tick, output nxt, output wrap16, output wrapn);
	modport chan (input tick, input nxt, input wrap16, input wrapn);
endinterface : pca_cnt_if

/* File: src/pca_pkg.sv */
// Purpose: Shared constants, register map and helpers of the counter array compare/PWM block
// Assumes: Byte-wide register port, three channels, 16-bit counter
// Notes:   Offsets, fields and reset values used by the logic live here, except the cycle length field [1:0] and its reset value
// Function
// - Compare and match enabled: flag set when counter equals 16-bit compare.
// - Set flag requests interrupt when enabled; stays set until software clears.
// - Low byte write clears compare enable; high byte write sets it.
// - Toggle, match, compare set: pin inverts and flag sets on 16-bit match.
// - High-speed mode with compare enable cleared holds the pin level.
// - Frequency mode toggles on low byte match, adds high byte (0 means 256).
// - Frequency mode with match enable flags only on full 16-bit equality.
// - Short PWM channels share one 8 to 11 bit cycle length.
// - 8-bit PWM sets pin on low byte match, clears on low byte overflow.
// - 8-bit PWM copies high byte into low byte on every low byte wrap.
// - 8-bit PWM selected by compare and pulse mode with length code 00.
// - 8-bit PWM flags each rising match; overflow flag every 256 counter clocks.
// - Reload view select steers compare byte addresses to reload register.
// - N-bit PWM sets pin when low N counter bits equal compare value.
// - Overflow out of bit N clears pin, sets overflow flag, loads reload.
// - Overflow every 512, 1024, 2048 clocks; match enable flags rising match.
// - Short PWM with compare enable cleared holds pin low.
// - 16-bit PWM sets pin on full match, clears on counter wrap.
// - 16-bit PWM selected by compare, pulse and wide bits; match flags.
// - Channel irq enable per channel; separate counter wrap irq enable.
// - Counter wrap from all ones to zero sets the counter wrap flag.
package pca_pkg;
	localparam int          NCH      = 3;
	// Register addresses
	localparam logic [7:0]  A_CTRL   = 8'h00;
	localparam logic [7:0]  A_AMODE  = 8'h01;
	localparam logic [7:0]  A_SPCFG  = 8'h02;
	localparam logic [7:0]  A_CNTL   = 8'h03;
	localparam logic [7:0]  A_CNTH   = 8'h04;
	localparam logic [7:0]  A_DIV    = 8'h05;
	localparam logic [7:0]  A_CHBASE = 8'h10;
	localparam logic [7:0]  A_CHSTEP = 8'h04;
	localparam logic [7:0]  O_MODE   = 8'h00;
	localparam logic [7:0]  O_LOW    = 8'h01;
	localparam logic [7:0]  O_HIGH   = 8'h02;
	// Channel mode register fields
	localparam int          M_WIDE   = 7;
	localparam int          M_ECOM   = 6;
	localparam int          M_MAT    = 3;
	localparam int          M_TOG    = 2;
	localparam int          M_PWM    = 1;
	localparam int          M_IRQ    = 0;
	// Control, array mode and short pulse config fields
	localparam int          C_CF     = 7;
	localparam int          C_RUN    = 6;
	localparam int          AM_ECF   = 0;
	localparam int          S_ECOV   = 7;
	localparam int          S_VIEW   = 6;
	localparam int          S_INTERMEDIATE_OVERFLOW_FLAG   = 5;
	// Widths and reset values
	localparam int          RLW      = 11;
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [15:0] ALL_ONES = 16'hffff;

	// Mask of the low N counter bits for a cycle length code
	function automatic logic [RLW-1:0] low_mask(input logic [1:0] cls);
		unique case (cls)
			2'b00: low_mask = 11'h0ff;
			2'b01: low_mask = 11'h1ff;
			2'b10: low_mask = 11'h3ff;
			2'b11: low_mask = 11'h7ff;
		endcase
	endfunction : low_mask

	// Byte address of a channel register
	function automatic logic [7:0] ch_addr(input int n, input logic [7:0] off);
		ch_addr = A_CHBASE + 8'(n) * A_CHSTEP + off;
	endfunction : ch_addr
endpackage : pca_pkg

/* File: src/pca_timebase.sv */
// Purpose: 16-bit counter with a simple tick divider and overflow pulses
// Assumes: Divider value d gives one counter step every d+1 system clocks
// Notes:   Software writes to the counter win over a step in the same cycle
`timescale 1ns/1ps
module pca_timebase (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        run,
	input  wire logic [7:0]  div,
	input  wire logic [1:0]  cls,
	input  wire logic        wr_lo,
	input  wire logic        wr_hi,
	input  wire logic [7:0]  wdata,
	output logic      [15:0] cnt_q,
	pca_cnt_if.src           cb
);
	logic [7:0]  pre_q;
	logic [10:0] m;

	// Step strobe and overflow detection on the value being left
	always_comb begin
		m         = pca_pkg::low_mask(cls);
		cb.tick   = run && (pre_q == div);
		cb.nxt    = cnt_q + 16'h0001;
		cb.wrap16 = cb.tick && (cnt_q == pca_pkg::ALL_ONES);
		cb.wrapn  = cb.tick && ((cnt_q[10:0] & m) == m);
	end

	// Prescaler
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_q <= pca_pkg::RST_BYTE;
		end else if (!run || cb.tick) begin
			pre_q <= pca_pkg::RST_BYTE;
		end else begin
			pre_q <= pre_q + 8'h01;
		end
	end

	// Counter
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= pca_pkg::RST_WORD;
		end else if (wr_lo) begin
			cnt_q[7:0] <= wdata;
		end else if (wr_hi) begin
			cnt_q[15:8] <= wdata;
		end else if (cb.tick) begin
			cnt_q <= cb.nxt;
		end
	end
endmodule : pca_timebase
